// ---- hw/hpb_port.sv ----
// Host processor bus port: access sequencer, requests and config port.
`timescale 1ns/100ps
`default_nettype none

module hpb_port (
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Host bus pins.
    input wire logic host_clk,
    input wire logic host_chip_select_n,
    input wire logic host_write_not_read_n,
    input wire logic host_write_data_strobe_n,
    input wire logic host_upper_half_select_n,
    input wire logic host_lower_half_select_n,
    input wire logic [hpb_pkg::HPB_ADDR_W-1:0] host_address_bus,
    input wire logic [hpb_pkg::HPB_DATA_W-1:0] host_data_bus_i,
    output logic [hpb_pkg::HPB_DATA_W-1:0] host_data_bus_o,
    output logic host_data_bus_oe,
    output logic host_transfer_ack_n_o,
    output logic host_transfer_ack_n_oe,
    output logic host_interrupt_n,
    output logic insert_array_request_n,
    output logic extract_array_request_n,
    output logic maintenance_window_request_n,
    // External memory bank selects.
    output logic [hpb_pkg::HPB_BANKS-1:0] ext_mem_upper_bank_select_n,
    output logic [hpb_pkg::HPB_BANKS-1:0] ext_mem_lower_bank_select_n,
    // Internal side.
    output logic core_req_valid,
    output hpb_pkg::hpb_req_type core_req,
    input wire logic core_resp_valid,
    input wire logic [hpb_pkg::HPB_DATA_W-1:0] core_rdata,
    input wire logic core_irq,
    input wire logic insert_ready,
    input wire logic extract_ready,
    input wire logic maint_due,
    output logic maint_cycle_start,
    // Configuration port.
    input wire logic [hpb_pkg::HPB_CFG_AW-1:0] cfg_addr,
    input wire logic [hpb_pkg::HPB_DATA_W-1:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic [hpb_pkg::HPB_DATA_W-1:0] cfg_rdata
);
    import hpb_pkg::*;

    hpb_pin_type pin_raw;
    hpb_pin_type pin_s;
    hpb_state_type state;
    hpb_state_type next_state;
    logic hclk_prev;
    logic hclk_fall;
    logic start_acc;
    logic acc_write;
    logic acc_maint;
    logic acc_up_n;
    logic acc_lo_n;
    logic acc_ack_en;
    logic [HPB_ADDR_W-1:0] acc_addr;
    logic [HPB_BANK_W-1:0] acc_bank;
    logic [HPB_BANKS-1:0] bank_hit;
    logic [HPB_BANKS-1:0] next_up_n;
    logic [HPB_BANKS-1:0] next_lo_n;
    logic maint_live;
    logic wdata_take;
    logic acc_end;
    logic next_ack_en;
    logic [HPB_CTRL_W-1:0] cfg_ctrl;
    logic [HPB_CNT_W-1:0] cfg_mlead;
    logic [HPB_CNT_W-1:0] cfg_mcount;
    logic [HPB_CNT_W-1:0] lead_cnt;
    logic [HPB_CNT_W-1:0] maint_done;
    logic lead_run;
    logic maint_active;
    logic maint_open;
    logic maint_finish;
    logic [HPB_DATA_W-1:0] status_word;
    logic [HPB_DATA_W-1:0] next_cfg_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Pin retiming. The host clock is only sampled, never used as a clock.
    assign pin_raw = '{hclk: host_clk, sel_n: host_chip_select_n,
                       wr_n: host_write_not_read_n, ds_n: host_write_data_strobe_n,
                       up_n: host_upper_half_select_n, lo_n: host_lower_half_select_n,
                       addr: host_address_bus, data: host_data_bus_i};

    hpb_sync #(
        .WIDTH(HPB_PIN_W)
    ) u_pin_sync (
        .mclk(mclk),
        .srst(srst),
        .d(pin_raw),
        .q(pin_s)
    );

    // Falling host clock edge, found from the retimed copy only.
    always_ff @(posedge mclk) begin
        if (srst) begin
            hclk_prev <= 1'b1;
        end else begin
            hclk_prev <= pin_s.hclk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access decode. Everything the host drives is judged at falling edges, except the data bus enable, which follows select every cycle.
    assign hclk_fall = hclk_prev & ~pin_s.hclk;
    assign start_acc = hclk_fall & ~pin_s.sel_n & (state == HPB_ST_IDLE);
    assign wdata_take = hclk_fall & ~pin_s.ds_n & (state == HPB_ST_WDATA);
    assign acc_end = hclk_fall & pin_s.sel_n;
    assign acc_bank = acc_addr[HPB_BANK_LSB +: HPB_BANK_W];
    assign bank_hit = HPB_BANK_ONE << acc_bank;
    assign maint_live = acc_maint & (state != HPB_ST_IDLE);
    // Only the addressed bank follows the host half selects; others stay idle.
    assign next_up_n = maint_live ? ~(bank_hit & {HPB_BANKS{~acc_up_n}}) : HPB_BANK_IDLE;
    assign next_lo_n = maint_live ? ~(bank_hit & {HPB_BANKS{~acc_lo_n}}) : HPB_BANK_IDLE;
    // Suppression is chosen per access type from the control register.
    assign next_ack_en = pin_s.addr[HPB_MAINT_BIT] ? ~cfg_ctrl[HPB_ACKOFF_MT] :
                         ~pin_s.wr_n ? ~cfg_ctrl[HPB_ACKOFF_WR] :
                         ~cfg_ctrl[HPB_ACKOFF_RD];

    // Sequencer next state.
    always_comb begin
        next_state = state;
        case (state)
            HPB_ST_IDLE: begin
                if (start_acc) begin
                    next_state = pin_s.wr_n ? HPB_ST_RDWAIT : HPB_ST_WDATA;
                end
            end
            HPB_ST_RDWAIT: begin
                if (core_resp_valid) begin
                    next_state = HPB_ST_ACK;
                end
            end
            HPB_ST_WDATA: begin
                if (wdata_take) begin
                    next_state = HPB_ST_ACK;
                end else if (acc_end) begin
                    next_state = HPB_ST_RELEASE;
                end
            end
            HPB_ST_ACK: begin
                if (acc_end) begin
                    next_state = HPB_ST_RELEASE;
                end
            end
            HPB_ST_RELEASE: begin
                next_state = HPB_ST_IDLE;
            end
            default: begin
                next_state = HPB_ST_IDLE;
            end
        endcase
    end

    // Access context, taken once as select is first seen low.
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= HPB_ST_IDLE;
            acc_addr <= HPB_ADDR_ZERO;
            acc_write <= 1'b0;
            acc_maint <= 1'b0;
            acc_up_n <= 1'b1;
            acc_lo_n <= 1'b1;
            acc_ack_en <= 1'b0;
        end else begin
            state <= next_state;
            if (start_acc) begin
                acc_addr <= pin_s.addr;
                acc_write <= ~pin_s.wr_n;
                acc_maint <= pin_s.addr[HPB_MAINT_BIT];
                acc_up_n <= pin_s.up_n;
                acc_lo_n <= pin_s.lo_n;
                acc_ack_en <= next_ack_en;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request to the internal logic: reads at start, writes at data capture.
    always_ff @(posedge mclk) begin
        if (srst) begin
            core_req_valid <= 1'b0;
            core_req <= '0;
        end else begin
            core_req_valid <= (start_acc & pin_s.wr_n) | wdata_take;
            if (start_acc) begin
                core_req <= '{write: ~pin_s.wr_n, maint: pin_s.addr[HPB_MAINT_BIT],
                              up_n: pin_s.up_n, lo_n: pin_s.lo_n,
                              addr: pin_s.addr, wdata: HPB_DATA_ZERO};
            end else if (wdata_take) begin
                core_req.wdata <= pin_s.data;
            end
        end
    end

    // Data bus drive and acknowledge. The acknowledge follows mclk, so it
    // bears no phase relation to the host clock and must be synchronised.
    always_ff @(posedge mclk) begin
        if (srst) begin
            host_data_bus_o <= HPB_DATA_ZERO;
            host_data_bus_oe <= 1'b0;
            host_transfer_ack_n_o <= 1'b1;
            host_transfer_ack_n_oe <= 1'b0;
        end else begin
            if (state == HPB_ST_RDWAIT && core_resp_valid) begin
                host_data_bus_o <= core_rdata;
            end
            host_data_bus_oe <= ~pin_s.sel_n & pin_s.wr_n;
            host_transfer_ack_n_o <= (next_state != HPB_ST_ACK);
            host_transfer_ack_n_oe <= acc_ack_en & ((next_state == HPB_ST_ACK) |
                                      (next_state == HPB_ST_RELEASE));
        end
    end

    // Bank selects mirror the host half selects during maintenance access.
    always_ff @(posedge mclk) begin
        if (srst) begin
            ext_mem_upper_bank_select_n <= HPB_BANK_IDLE;
            ext_mem_lower_bank_select_n <= HPB_BANK_IDLE;
        end else begin
            ext_mem_upper_bank_select_n <= next_up_n;
            ext_mem_lower_bank_select_n <= next_lo_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Maintenance window: request first, cycle opens after the lead count,
    // closes once the programmed number of maintenance accesses has ended.
    assign maint_finish = maint_open & acc_maint & acc_end &
                          (state == HPB_ST_ACK) & (maint_done + HPB_CNT_ONE >= cfg_mcount);

    always_ff @(posedge mclk) begin
        if (srst) begin
            lead_cnt <= HPB_CNT_ZERO;
            lead_run <= 1'b0;
            maint_active <= 1'b0;
            maint_open <= 1'b0;
            maint_done <= HPB_CNT_ZERO;
            maint_cycle_start <= 1'b0;
        end else begin
            maint_cycle_start <= lead_run & (lead_cnt == HPB_CNT_ZERO);
            if (maint_due & ~maint_active) begin
                maint_active <= 1'b1;
                lead_run <= 1'b1;
                lead_cnt <= cfg_mlead;
                maint_done <= HPB_CNT_ZERO;
            end else if (lead_run) begin
                if (lead_cnt == HPB_CNT_ZERO) begin
                    lead_run <= 1'b0;
                    maint_open <= 1'b1;
                end else begin
                    lead_cnt <= lead_cnt - HPB_CNT_ONE;
                end
            end else if (maint_finish) begin
                maint_active <= 1'b0;
                maint_open <= 1'b0;
            end else if (maint_open & acc_maint & acc_end & (state == HPB_ST_ACK)) begin
                maint_done <= maint_done + HPB_CNT_ONE;
            end
        end
    end

    // Host-side requests change only at falling host edges; the interrupt
    // follows the master clock directly.
    always_ff @(posedge mclk) begin
        if (srst) begin
            insert_array_request_n <= 1'b1;
            extract_array_request_n <= 1'b1;
            maintenance_window_request_n <= 1'b1;
            host_interrupt_n <= 1'b1;
        end else begin
            if (hclk_fall) begin
                insert_array_request_n <= ~insert_ready;
                extract_array_request_n <= ~extract_ready;
                maintenance_window_request_n <= ~maint_active;
            end
            host_interrupt_n <= ~core_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration port. Unmapped offsets read zero and ignore writes.
    assign status_word = {16'h0000, maint_done, 3'h0, maint_open, maint_active, state};
    assign next_cfg_rdata = (cfg_addr == HPB_CFG_CTRL) ? {29'h0000_0000, cfg_ctrl} :
                            (cfg_addr == HPB_CFG_MLEAD) ? {24'h00_0000, cfg_mlead} :
                            (cfg_addr == HPB_CFG_MCOUNT) ? {24'h00_0000, cfg_mcount} :
                            (cfg_addr == HPB_CFG_STATUS) ? status_word : HPB_DATA_ZERO;

    always_ff @(posedge mclk) begin
        if (srst) begin
            cfg_ctrl <= HPB_CTRL_RST;
            cfg_mlead <= HPB_MLEAD_RST;
            cfg_mcount <= HPB_MCOUNT_RST;
            cfg_rdata <= HPB_DATA_ZERO;
        end else begin
            if (cfg_wr && cfg_addr == HPB_CFG_CTRL) begin
                cfg_ctrl <= cfg_wdata[HPB_CTRL_W-1:0];
            end
            if (cfg_wr && cfg_addr == HPB_CFG_MLEAD) begin
                cfg_mlead <= cfg_wdata[HPB_CNT_W-1:0];
            end
            if (cfg_wr && cfg_addr == HPB_CFG_MCOUNT) begin
                cfg_mcount <= cfg_wdata[HPB_CNT_W-1:0];
            end
            cfg_rdata <= cfg_rd ? next_cfg_rdata : HPB_DATA_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_read_done;
        (state == HPB_ST_RDWAIT) && core_resp_valid;
    endsequence

    sequence s_release;
        state == HPB_ST_RELEASE;
    endsequence

    AST_OE_READ_ONLY: assert property (host_data_bus_oe |->
        $past(!pin_s.sel_n) && $past(pin_s.wr_n)) else $error("data driven outside read");
    AST_WRITE_DECODE: assert property (start_acc && !pin_s.wr_n |=>
        state == HPB_ST_WDATA && acc_write) else $error("write not decoded");
    AST_ADDR_TAKEN: assert property (start_acc |=>
        acc_addr == $past(pin_s.addr) && core_req.addr == $past(pin_s.addr))
        else $error("address not captured");
    AST_READ_ACK: assert property (s_read_done ##0 acc_ack_en |=>
        !host_transfer_ack_n_o && host_transfer_ack_n_oe &&
        host_data_bus_o == $past(core_rdata)) else $error("read ack wrong");
    AST_ACK_PULLUP: assert property (s_release |-> host_transfer_ack_n_o &&
        host_transfer_ack_n_oe == acc_ack_en ##1 !host_transfer_ack_n_oe)
        else $error("ack not released");
    AST_ACK_MASKED: assert property (!acc_ack_en && state != HPB_ST_IDLE |=>
        !host_transfer_ack_n_oe) else $error("suppressed ack driven");
    AST_IRQ: assert property (core_irq ##1 core_irq |-> !host_interrupt_n)
        else $error("interrupt not asserted");
    AST_INSERT_REQ: assert property (hclk_fall |=>
        insert_array_request_n == !$past(insert_ready)) else $error("insert req wrong");
    AST_EXTRACT_REQ: assert property (!hclk_fall |=>
        $stable(extract_array_request_n)) else $error("extract req off edge");
    AST_BANK_COPY: assert property (maint_live && state == HPB_ST_ACK |=>
        ext_mem_upper_bank_select_n[acc_bank] == acc_up_n &&
        ext_mem_lower_bank_select_n[acc_bank] == acc_lo_n) else $error("bank copy wrong");
    AST_MAINT_LEAD: assert property ($rose(maint_active) |->
        !maint_open ##1 !maint_open) else $error("maintenance opened early");
    AST_MAINT_END: assert property (maint_finish |=>
        !maint_active ##[1:1000] maintenance_window_request_n)
        else $error("maintenance request not released");

endmodule // hpb_port

`default_nettype wire

// ---- hw/hpb_sync.sv ----
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/100ps
`default_nettype none

module hpb_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Asynchronous input and retimed output.
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second; nothing else may look at it.
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta <= '1;
            q <= '1;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // hpb_sync

`default_nettype wire

// ---- include/hpb_pkg.sv ----
// Constants, types and bit layouts shared by the host bus port files.
// What this block does
// - Direction low means write, high means read
// - Drive data only when selected and reading
// - Upper select marks upper half, lower marks lower
// - Maintenance access copies half selects to banks
// - Acknowledge when read data valid or write captured
// - Acknowledge driven high briefly, then released
// - Programmable acknowledge suppression per access type
// - Acknowledge timing not aligned to host clock
// - Interrupt asserted on master clock rising edge
// - Insert request low while insert array free
// - Extract request low while extract cell ready
// - Maintenance request leads maintenance cycle programmably
// - Maintenance request released after programmed access count
// - Access valid only while select sampled low
// - Address captured when select first seen low
// - Bank selects active low, upper and lower
`default_nettype none

package hpb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int HPB_ADDR_W = 24;
    localparam int HPB_DATA_W = 32;
    localparam int HPB_BANKS = 4;
    localparam int HPB_BANK_W = 2;
    localparam int HPB_CNT_W = 8;
    localparam int HPB_CFG_AW = 4;
    localparam int HPB_PIN_W = 62;

    // Address layout: top bit selects external memory maintenance space.
    localparam int HPB_MAINT_BIT = 23;
    localparam int HPB_BANK_LSB = 21;

    ////////////////////////////////////////////////////////////////////////////
    // Local configuration port map.
    localparam logic [HPB_CFG_AW-1:0] HPB_CFG_CTRL = 4'h0;
    localparam logic [HPB_CFG_AW-1:0] HPB_CFG_MLEAD = 4'h4;
    localparam logic [HPB_CFG_AW-1:0] HPB_CFG_MCOUNT = 4'h8;
    localparam logic [HPB_CFG_AW-1:0] HPB_CFG_STATUS = 4'hC;

    // Control bits: suppress acknowledge for reads, writes, maintenance.
    localparam int HPB_ACKOFF_RD = 0;
    localparam int HPB_ACKOFF_WR = 1;
    localparam int HPB_ACKOFF_MT = 2;
    localparam int HPB_CTRL_W = 3;

    // Reset values.
    localparam logic [HPB_CTRL_W-1:0] HPB_CTRL_RST = 3'h0;
    localparam logic [HPB_CNT_W-1:0] HPB_MLEAD_RST = 8'h04;
    localparam logic [HPB_CNT_W-1:0] HPB_MCOUNT_RST = 8'h01;
    localparam logic [HPB_CNT_W-1:0] HPB_CNT_ZERO = 8'h00;
    localparam logic [HPB_CNT_W-1:0] HPB_CNT_ONE = 8'h01;
    localparam logic [HPB_BANKS-1:0] HPB_BANK_ONE = 4'h1;
    localparam logic [HPB_BANKS-1:0] HPB_BANK_IDLE = 4'hF;
    localparam logic [HPB_DATA_W-1:0] HPB_DATA_ZERO = 32'h0000_0000;
    localparam logic [HPB_ADDR_W-1:0] HPB_ADDR_ZERO = 24'h00_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer states.
    typedef enum logic [2:0] {
        HPB_ST_IDLE = 3'b000,
        HPB_ST_RDWAIT = 3'b001,
        HPB_ST_WDATA = 3'b010,
        HPB_ST_ACK = 3'b011,
        HPB_ST_RELEASE = 3'b100
    } hpb_state_type;

    // Host pins as they arrive, bundled for the synchroniser.
    typedef struct packed {
        logic hclk;
        logic sel_n;
        logic wr_n;
        logic ds_n;
        logic up_n;
        logic lo_n;
        logic [HPB_ADDR_W-1:0] addr;
        logic [HPB_DATA_W-1:0] data;
    } hpb_pin_type;

    // Access handed to the internal register and memory logic.
    typedef struct packed {
        logic write;
        logic maint;
        logic up_n;
        logic lo_n;
        logic [HPB_ADDR_W-1:0] addr;
        logic [HPB_DATA_W-1:0] wdata;
    } hpb_req_type;

endpackage

`default_nettype wire

// ---- tb/hpb_host_model.sv ----
// Behavioural host processor that runs accesses on the asynchronous bus port.
`timescale 1ns/100ps
`default_nettype none

module hpb_host_model (
    // Pins driven toward the port.
    output logic host_clk,
    output logic sel_n,
    output logic wr_n,
    output logic ds_n,
    output logic up_n,
    output logic lo_n,
    output logic [23:0] addr,
    output logic [31:0] wdata,
    output logic wdrv,
    // Resolved wires seen back.
    input wire logic ack_n,
    input wire logic [31:0] bus
);
    // The processor clock runs free with an 80 ns period; all strobes idle high.
    initial begin
        host_clk = 1'b0;
        {sel_n, wr_n, ds_n, up_n, lo_n, wdrv} = 6'h3e;
        addr = 24'h00_0000;
        wdata = 32'h0000_0000;
    end
    always #40 host_clk = ~host_clk;

    // Pins move just after a rising host edge so the port sees them steady when it samples.
    task automatic xfer(input logic w, input logic [23:0] a, input logic [31:0] d,
            input logic [1:0] hs, output logic [31:0] rd, output logic ok);
        int n;
        @(posedge host_clk);
        {sel_n, wr_n, up_n, lo_n, addr, wdata} <= {1'b0, ~w, hs, a, d};
        @(posedge host_clk);
        {ds_n, wdrv} <= {~w, w};
        ok = 1'b0;
        for (n = 0; n < 6 && !ok; n++) begin
            @(posedge host_clk);
            ok = (ack_n === 1'b0);
        end
        rd = bus;
        {sel_n, ds_n, wdrv} <= 3'b110;
        repeat (3) @(posedge host_clk);
    endtask
endmodule // hpb_host_model

`default_nettype wire

// ---- tb/tb_top.sv ----
// Top-level bench for the host bus port with a host model and a small core model.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import hpb_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic h_clk, sel_n, wr_n, ds_n, up_n, lo_n, hdrv, doe, ack_o, ack_oe, irq_n, ins_n;
    logic ext_n, mnt_n, crv, mstart, resp, irq, ins_r, ext_r, mdue, cwr, crd, ack_hi, oe_seen;
    logic [3:0] ubs, lbs, cfa;
    logic [7:0] banks;
    logic [23:0] haddr;
    logic [31:0] hwd, dout, rdat, cfd, cfq, bus_q;
    hpb_req_type creq, last_req;
    int err_count = 0;
    int comparisons = 0;
    // Acknowledge has a pull-up; an undriven data bus shows a changing pattern.
    wire logic ack_w = ack_oe ? ack_o : 1'b1;
    wire logic [31:0] bus_w = doe ? dout : hdrv ? hwd : ~bus_q;
    // Watched levels: 4 interrupt, 3 insert, 2 extract, 1 maintenance, 0 window start.
    wire logic [4:0] pins = {irq_n, ins_n, ext_n, mnt_n, mstart};

    hpb_host_model host (.host_clk(h_clk), .sel_n(sel_n), .wr_n(wr_n), .ds_n(ds_n),
        .up_n(up_n), .lo_n(lo_n), .addr(haddr), .wdata(hwd), .wdrv(hdrv), .ack_n(ack_w),
        .bus(bus_w));
    hpb_port DUT (.mclk(mclk), .srst(srst), .host_clk(h_clk), .host_chip_select_n(sel_n),
        .host_write_not_read_n(wr_n), .host_write_data_strobe_n(ds_n),
        .host_upper_half_select_n(up_n), .host_lower_half_select_n(lo_n),
        .host_address_bus(haddr), .host_data_bus_i(bus_w), .host_data_bus_o(dout),
        .host_data_bus_oe(doe), .host_transfer_ack_n_o(ack_o), .host_transfer_ack_n_oe(ack_oe),
        .host_interrupt_n(irq_n), .insert_array_request_n(ins_n),
        .extract_array_request_n(ext_n), .maintenance_window_request_n(mnt_n),
        .ext_mem_upper_bank_select_n(ubs), .ext_mem_lower_bank_select_n(lbs),
        .core_req_valid(crv), .core_req(creq), .core_resp_valid(resp), .core_rdata(rdat),
        .core_irq(irq), .insert_ready(ins_r), .extract_ready(ext_r), .maint_due(mdue),
        .maint_cycle_start(mstart), .cfg_addr(cfa), .cfg_wdata(cfd), .cfg_wr(cwr),
        .cfg_rd(crd), .cfg_rdata(cfq));

    always #4 mclk = ~mclk;

    // Core model answers a read one cycle after its request; observers latch what they saw.
    always @(posedge mclk) begin
        resp <= crv & ~creq.write;
        rdat <= {8'h5a, creq.addr};
        bus_q <= bus_w;
        if (crv) last_req <= creq;
        if (ack_oe && ack_o) ack_hi <= 1'b1;
        if (doe) oe_seen <= 1'b1;
        if ({ubs, lbs} != 8'hff) banks <= {ubs, lbs};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare, count, and report a mismatch at once.
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Bounded wait for a level; running out of cycles ends the run.
    task automatic wait_for(input int i, input logic v, input int lim, input string n);
        for (int k = 0; k < lim && pins[i] !== v; k++) begin
            @(posedge mclk);
            #1;
        end
        check(n, {31'h0, v}, {31'h0, pins[i]});
        if (pins[i] !== v) give_verdict();
    endtask

    task automatic cfgw(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        {cfa, cfd, cwr} <= {a, d, 1'b1};
        @(posedge mclk);
        cwr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic cfgr(input logic [3:0] a, input logic [31:0] e, input string n);
        @(posedge mclk);
        {cfa, crd} <= {a, 1'b1};
        @(posedge mclk);
        crd <= 1'b0;
        #1 check(n, e, cfq);
    endtask

    // One host access, then checks of what the port passed on and drove.
    task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d,
            input logic [1:0] hs, input logic ack);
        logic [31:0] rd;
        logic ok;
        logic [7:0] eb;
        eb = 8'hff;
        if (a[23]) begin
            eb[4 + a[22:21]] = hs[1];
            eb[a[22:21]] = hs[0];
        end
        {ack_hi, oe_seen, banks} = 10'h0ff;
        host.xfer(w, a, d, hs, rd, ok);
        check("ack", {31'h0, ack}, {31'h0, ok});
        check("req", {6'h0, a[23], w, a},
            {6'h0, last_req.maint, last_req.write, last_req.addr});
        check("halves", {30'h0, hs}, {30'h0, last_req.up_n, last_req.lo_n});
        if (w || ack) check("data", w ? d : {8'h5a, a}, w ? last_req.wdata : rd);
        check("drive", {30'h0, ~w, ack}, {30'h0, oe_seen, ack_hi});
        check("banks", {24'h0, eb}, {24'h0, banks});
        check("release", 32'h0, {31'h0, ack_oe});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {resp, irq, ins_r, ext_r, mdue, cwr, crd, cfa} = 11'h000;
        {rdat, cfd, bus_q} = 96'h0;
        {ack_hi, oe_seen, banks} = 10'h0ff;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 check("idle", 32'h0000_3fcf, {18'h0, ubs, lbs, ack_oe, doe, pins[4:1]});
        cfgr(HPB_CFG_CTRL, 32'h0000_0000, "ctrl");
        cfgr(HPB_CFG_MLEAD, 32'h0000_0004, "lead");
        cfgr(HPB_CFG_MCOUNT, 32'h0000_0001, "count");
        cfgw(4'h2, 32'hffff_ffff);
        cfgr(4'h2, 32'h0000_0000, "unmapped");
        $display("test config done");
        acc(1'b0, 24'h00_0104, 32'h0000_0000, 2'b00, 1'b1);
        acc(1'b1, 24'h00_0208, 32'hdead_beef, 2'b00, 1'b1);
        $display("test access done");
        @(posedge mclk);
        {ins_r, ext_r, irq} <= 3'b101;
        wait_for(4, 1'b0, 2, "irq");
        wait_for(3, 1'b0, 30, "insert");
        check("extract", 32'h0000_0001, {31'h0, ext_n});
        @(posedge mclk);
        {ins_r, ext_r, irq} <= 3'b010;
        wait_for(4, 1'b1, 2, "irq off");
        wait_for(2, 1'b0, 30, "extract");
        wait_for(3, 1'b1, 30, "insert off");
        $display("test requests done");
        cfgw(HPB_CFG_MCOUNT, 32'h0000_0002);
        @(posedge mclk);
        mdue <= 1'b1;
        @(posedge mclk);
        mdue <= 1'b0;
        wait_for(0, 1'b1, 12, "window");
        wait_for(1, 1'b0, 30, "maint");
        acc(1'b1, 24'hc0_0010, 32'h1234_5678, 2'b01, 1'b1);
        check("maint held", 32'h0000_0000, {31'h0, mnt_n});
        // One access counted, window open and requested, sequencer idle.
        cfgr(HPB_CFG_STATUS, 32'h0000_0118, "status");
        acc(1'b0, 24'ha0_0020, 32'h0000_0000, 2'b10, 1'b1);
        wait_for(1, 1'b1, 30, "maint off");
        $display("test maintenance done");
        for (int k = 0; k < 3; k++) begin
            cfgw(HPB_CFG_CTRL, 32'h0000_0001 << k);
            acc(k == 1, {k == 2, 23'h00_0040}, 32'ha5a5_a5a5, 2'b00, 1'b0);
        end
        $display("test suppression done");
        give_verdict();
    end
endmodule // tb_top

`default_nettype wire
